// ==== rtl/uopc_ctrl.sv ====
// USB line, power and error-interrupt control registers on AHB-Lite.
// Notes on behaviour
// - Bits 7..4 enable D+ and D- pull-ups, then D+ and D- pull-downs.
// - Line-switch bit 2 high gives software the resistors, else hardware.
// - Bit 3 drives bus power on when set, off when clear.
// - Bit 1 charges bus power through a pull-up when set.
// - Bit 0 discharges bus power through a pull-down when set.
// - Bits 31..8 of each register always read zero.
// - Power bit 7 reads one while activity is seen but interrupt pending.
// - Guard bit 4 blocks sleep during activity or pending notice.
// - Busy bit 3 reads one while active or not yet ready to enable.
// - Suspend bit 1 gates the 48 MHz clock and idles the transceiver.
// - Enable bit 0 turns on; clear holds outputs inactive, releases pins.
// - Error enables 7..2 gate stuff, matrix, DMA, timeout, size, CRC16.
// - Error enable 1 gates CRC5 in device mode, frame end in host mode.
// - Error enable 0 gates the packet ID check failure.
// - Errors reach the combined interrupt only with summary enable set.
// - Clear, set and invert aliases at base plus 0x4, 0x8, 0xc.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module uopc_ctrl (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // USB core side
  input  wire logic                 hw_line_dp_pu,
  input  wire logic                 hw_line_dm_pu,
  input  wire logic                 hw_line_dp_pd,
  input  wire logic                 hw_line_dm_pd,
  input  wire logic                 bus_activity,
  input  wire logic                 activity_irq_done,
  input  wire logic                 phy_ready,
  input  wire logic [7:0]           error_flags,
  input  wire logic                 host_mode,
  input  wire logic                 sleep_req,
  // Pin and power controls
  output uopc_pkg::uopc_line_s      line_res,
  output logic                      bus_power_on,
  output logic                      bus_power_charge_en,
  output logic                      bus_power_discharge_en,
  output logic                      usb_clk_gate_en,
  output logic                      xcvr_low_power,
  output logic                      pins_owned,
  output logic                      sleep_block,
  output logic                      module_irq_out,
  output logic                      error_summary_irq,
  output logic                      irq
);

  // Asynchronous pins pass two flip-flops first.
  // The mode pin only renames error-enable bit 1; the gate does not
  // depend on it, so its synchronised copy is kept for visibility only.
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;
  logic [13:0] pins_raw;
  assign pins_raw = {hw_line_dp_pu, hw_line_dm_pu, hw_line_dp_pd,
                     hw_line_dm_pd, bus_activity, activity_irq_done,
                     error_flags};
  logic sp1_q;
  logic sp2_q;
  logic hm1_q;
  logic hm2_q;
  logic pr1_q;
  logic pr2_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sp1_q   <= 1'b0;
      sp2_q   <= 1'b0;
      hm1_q   <= 1'b0;
      hm2_q   <= 1'b0;
      pr1_q   <= 1'b0;
      pr2_q   <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sp1_q   <= sleep_req;
      sp2_q   <= sp1_q;
      hm1_q   <= host_mode;
      hm2_q   <= hm1_q;
      pr1_q   <= phy_ready;
      pr2_q   <= pr1_q;
    end
  end

  uopc_pkg::uopc_line_s hw_line;
  logic                 act_s;
  logic                 act_done_s;
  logic [7:0]           err_s;
  assign hw_line    = sync2_q[13:10];
  assign act_s      = sync2_q[9];
  assign act_done_s = sync2_q[8];
  assign err_s      = sync2_q[7:0];

  // AHB address phase capture.
  // Only the low address byte is decoded, so the register set repeats
  // across whatever window hsel covers.
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       take;
  assign take = hsel && hready && htrans == uopc_pkg::HTRANS_NONSEQ;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // Write decode: one register and one alias kind.
  // An offset that is none of the four kinds leaves the register as it
  // was, so stray byte addresses inside a register do no harm.
  logic [7:0] base_a;
  logic [3:0] alias_a;
  assign base_a  = {addr_q[7:4], 4'h0};
  assign alias_a = addr_q[3:0];

  function automatic logic [7:0] apply_alias(input logic [7:0] cur,
                                             input logic [7:0] wd,
                                             input logic [3:0] kind);
    logic [7:0] r;
    r = cur;
    if (kind == uopc_pkg::ALIAS_PLAIN) begin
      r = wd;
    end else if (kind == uopc_pkg::ALIAS_CLR) begin
      r = cur & ~wd;
    end else if (kind == uopc_pkg::ALIAS_SET) begin
      r = cur | wd;
    end else if (kind == uopc_pkg::ALIAS_INV) begin
      r = cur ^ wd;
    end
    return r;
  endfunction

  logic [7:0] line_q;
  logic [7:0] pwr_q;
  logic [7:0] eie_q;
  logic [7:0] mask_q;
  logic [7:0] main_q;
  logic [7:0] stat_q;
  logic       busy;
  logic       act_pend_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= uopc_pkg::RST_BYTE;
      pwr_q  <= uopc_pkg::RST_BYTE;
      eie_q  <= uopc_pkg::RST_BYTE;
      mask_q <= uopc_pkg::RST_BYTE;
      main_q <= uopc_pkg::RST_BYTE;
    end else if (wr_pend_q) begin
      if (base_a == uopc_pkg::OFS_LINE_CTRL) begin
        line_q <= apply_alias(line_q, hwdata[7:0], alias_a);
      end else if (base_a == uopc_pkg::OFS_POWER_CTRL) begin
        pwr_q <= apply_alias(pwr_q, hwdata[7:0], alias_a)
                 & uopc_pkg::PC_WMASK;
      end else if (base_a == uopc_pkg::OFS_ERR_EN) begin
        eie_q <= apply_alias(eie_q, hwdata[7:0], alias_a);
      end else if (base_a == uopc_pkg::OFS_EVT_MASK) begin
        mask_q <= apply_alias(mask_q, hwdata[7:0], alias_a);
      end else if (base_a == uopc_pkg::OFS_MAIN_IRQ) begin
        main_q <= apply_alias(main_q, hwdata[7:0], alias_a);
      end
    end
  end

  // Power sequencing: busy covers the settle time after power-up and the
  // wind-down after disable until the transceiver reports ready.
  // Writes made while off and busy are not refused; keeping clear of
  // that window is left to software.
  uopc_pkg::uopc_pstate_e pst_q;
  logic [7:0]             settle_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_q    <= uopc_pkg::PS_OFF;
      settle_q <= 8'h00;
    end else begin
      case (pst_q)
        uopc_pkg::PS_OFF: begin
          settle_q <= 8'h00;
          if (pwr_q[uopc_pkg::PC_PWR]) begin
            pst_q <= uopc_pkg::PS_SETTLE;
          end
        end
        uopc_pkg::PS_SETTLE: begin
          if (!pwr_q[uopc_pkg::PC_PWR]) begin
            pst_q <= uopc_pkg::PS_OFF;
          end else if (settle_q == uopc_pkg::SETTLE_LAST) begin
            pst_q <= uopc_pkg::PS_ON;
          end else begin
            settle_q <= settle_q + 8'h01;
          end
        end
        uopc_pkg::PS_ON: begin
          if (!pwr_q[uopc_pkg::PC_PWR]) begin
            pst_q <= uopc_pkg::PS_OFF;
          end
        end
        default: pst_q <= uopc_pkg::PS_OFF;
      endcase
    end
  end

  // Busy while on, settling, or off but the transceiver not yet ready.
  assign busy = (pst_q != uopc_pkg::PS_OFF) || !pr2_q;

  // Activity pending: set on activity while enabled, cleared once the interrupt fires.
  // Set wins over the done strobe, so activity that arrives just as the
  // interrupt is reported is not lost.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_pend_q <= 1'b0;
    end else if (act_s && pwr_q[uopc_pkg::PC_PWR]) begin
      act_pend_q <= 1'b1;
    end else if (act_done_s) begin
      act_pend_q <= 1'b0;
    end
  end

  // Error summary from flags and their enables.
  logic [7:0] err_gated;
  logic       err_any;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_err
      // Bit 1 is CRC5 in device mode and frame end in host mode; the core
      // routes the matching flag there, so the gate is the same.
      assign err_gated[gi] = err_s[gi]
                             & eie_q[gi];
    end
  endgenerate
  assign err_any = |err_gated;

  // Event status: sticky, cleared by a read; a new event wins the clear.
  logic [7:0] ev_now;
  logic       busy_q;
  logic       stat_rd;
  always_comb begin
    ev_now = 8'h00;
    ev_now[uopc_pkg::EV_ACT]  = act_s && !act_pend_q;
    ev_now[uopc_pkg::EV_ERR]  = err_any;
    ev_now[uopc_pkg::EV_BUSY] = busy_q && !busy;
  end
  assign stat_rd = rd_pend_q && addr_q == uopc_pkg::OFS_EVT_STATUS;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= uopc_pkg::RST_BYTE;
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
      stat_q <= (stat_rd ? 8'h00 : stat_q) | ev_now;
    end
  end

  // Read data, zero above bit 7 and for unmapped addresses.
  // Alias offsets read back the register itself.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (base_a == uopc_pkg::OFS_LINE_CTRL) begin
      rd_byte = line_q;
    end else if (base_a == uopc_pkg::OFS_POWER_CTRL) begin
      rd_byte = pwr_q;
      rd_byte[uopc_pkg::PC_ACT]  = act_pend_q;
      rd_byte[uopc_pkg::PC_BUSY] = busy;
    end else if (base_a == uopc_pkg::OFS_ERR_EN) begin
      rd_byte = eie_q;
    end else if (base_a == uopc_pkg::OFS_EVT_STATUS) begin
      rd_byte = stat_q;
    end else if (base_a == uopc_pkg::OFS_EVT_MASK) begin
      rd_byte = mask_q;
    end else if (base_a == uopc_pkg::OFS_MAIN_IRQ) begin
      rd_byte = main_q;
    end
  end

  // Read data is registered, so a read costs one wait state: hrdata is
  // loaded at the end of the first data-phase cycle, from the address
  // captured the edge before, and the master takes it one edge later.
  // A read right behind a write to the same register sees the new value,
  // because the write lands at the edge that accepts the read.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= uopc_pkg::ZERO_WORD;
    end else begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // Ready drops for the one cycle after a read is accepted; writes and
  // idle cycles see no wait state. The response is always OKAY.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(take && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // Pin and power outputs; disable drops every output to inactive.
  // The line control register keeps its value while disabled, so
  // enabling again restores the last software setting.
  logic                 on;
  uopc_pkg::uopc_line_s sw_line;
  assign on      = pwr_q[uopc_pkg::PC_PWR];
  assign sw_line = line_q[uopc_pkg::LC_DP_PU:uopc_pkg::LC_DM_PD];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_res               <= '0;
      bus_power_on           <= 1'b0;
      bus_power_charge_en    <= 1'b0;
      bus_power_discharge_en <= 1'b0;
      usb_clk_gate_en        <= 1'b0;
      xcvr_low_power         <= 1'b1;
      pins_owned             <= 1'b0;
    end else begin
      if (!on) begin
        line_res <= '0;
      end else if (line_q[uopc_pkg::LC_SWCTL]) begin
        line_res <= sw_line;
      end else begin
        line_res <= hw_line;
      end
      bus_power_on           <= on && line_q[uopc_pkg::LC_VBUS];
      bus_power_charge_en    <= on && line_q[uopc_pkg::LC_CHG];
      bus_power_discharge_en <= on && line_q[uopc_pkg::LC_DIS];
      usb_clk_gate_en <= on && !pwr_q[uopc_pkg::PC_SUSP];
      xcvr_low_power  <= !on || pwr_q[uopc_pkg::PC_SUSP];
      pins_owned      <= on;
    end
  end

  // Sleep guard and interrupt outputs.
  // The guard only asks for sleep to be held off; the sleep controller
  // itself decides.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_block       <= 1'b0;
      module_irq_out    <= 1'b0;
      error_summary_irq <= 1'b0;
      irq               <= 1'b0;
    end else begin
      sleep_block <= pwr_q[uopc_pkg::PC_GUARD] && sp2_q
                     && (act_s || act_pend_q);
      error_summary_irq <= err_any;
      module_irq_out <= err_any && main_q[uopc_pkg::MI_ERR];
      irq <= |(stat_q & mask_q);
    end
  end

endmodule

// ==== rtl/uopc_pkg.sv ====
// Package for the USB line, power and error-interrupt control block.
package uopc_pkg;

  // Register byte offsets (word aligned); aliases add to the base.
  localparam logic [7:0] OFS_LINE_CTRL  = 8'h00;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h10;
  localparam logic [7:0] OFS_ERR_EN     = 8'h20;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h30;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h40;
  localparam logic [7:0] OFS_MAIN_IRQ   = 8'h50;
  localparam logic [3:0] ALIAS_PLAIN    = 4'h0;
  localparam logic [3:0] ALIAS_CLR      = 4'h4;
  localparam logic [3:0] ALIAS_SET      = 4'h8;
  localparam logic [3:0] ALIAS_INV      = 4'hc;

  // Field positions of the line control register.
  localparam int LC_DP_PU  = 7;
  localparam int LC_DM_PU  = 6;
  localparam int LC_DP_PD  = 5;
  localparam int LC_DM_PD  = 4;
  localparam int LC_VBUS   = 3;
  localparam int LC_SWCTL  = 2;
  localparam int LC_CHG    = 1;
  localparam int LC_DIS    = 0;

  // Field positions of the power control register.
  localparam int PC_ACT    = 7;
  localparam int PC_GUARD  = 4;
  localparam int PC_BUSY   = 3;
  localparam int PC_SUSP   = 1;
  localparam int PC_PWR    = 0;
  localparam logic [7:0] PC_WMASK = 8'h13;

  // Main interrupt enable: error summary enable position.
  localparam int MI_ERR    = 1;

  // Event status bits.
  localparam int EV_ACT    = 0;
  localparam int EV_ERR    = 1;
  localparam int EV_BUSY   = 2;

  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

  // Power-up settle time before the power state leaves settle for on.
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  typedef struct packed {
    logic dp_pullup;
    logic dm_pullup;
    logic dp_pulldown;
    logic dm_pulldown;
  } uopc_line_s;

  typedef enum logic [2:0] {
    PS_OFF    = 3'b001,
    PS_SETTLE = 3'b010,
    PS_ON     = 3'b100
  } uopc_pstate_e;

endpackage

// ==== verification/uopc_ctrl_sva.sv ====
// Port-level assertions for the USB line, power and error control block.
`timescale 1ns/1ps
module uopc_ctrl_sva (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  // Bus answers
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  // Core side causes
  input wire logic [7:0]           error_flags,
  input wire logic                 sleep_req,
  // Pin, power and interrupt outputs
  input wire uopc_pkg::uopc_line_s line_res,
  input wire logic                 bus_power_on,
  input wire logic                 bus_power_charge_en,
  input wire logic                 bus_power_discharge_en,
  input wire logic                 usb_clk_gate_en,
  input wire logic                 xcvr_low_power,
  input wire logic                 pins_owned,
  input wire logic                 sleep_block,
  input wire logic                 module_irq_out,
  input wire logic                 error_summary_irq,
  input wire logic                 irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_bus_okay: assert property (!hresp)
    else $error("bus answer not okay");
  chk_wait_one: assert property (!hreadyout |=> hreadyout)
    else $error("more than one wait state");
  // Three quiet cycles let the output register catch up with the enable.
  chk_off_outputs: assert property (!pins_owned [*3] |->
    !bus_power_on && !bus_power_charge_en && !bus_power_discharge_en
    && line_res == 4'h0) else $error("outputs active while disabled");
  chk_off_lowpow: assert property (!pins_owned [*3] |->
    xcvr_low_power && !usb_clk_gate_en)
    else $error("transceiver awake while disabled");
  chk_clk_gate: assert property (usb_clk_gate_en |->
    !xcvr_low_power) else $error("clock runs in low power");
  chk_err_quiet: assert property (error_flags == 8'h00 [*6] |->
    !error_summary_irq) else $error("error summary without a flag");
  chk_irq_quiet: assert property (error_flags == 8'h00 [*8] |->
    !module_irq_out) else $error("module interrupt without a flag");
  chk_irq_gate: assert property (module_irq_out |->
    error_summary_irq || $past(error_summary_irq))
    else $error("module interrupt without error summary");
  chk_sleep_quiet: assert property (!sleep_req [*6] |->
    !sleep_block) else $error("sleep blocked without request");

  cov_enable: cover property ($rose(pins_owned));
  cov_mod_irq: cover property ($rose(module_irq_out));
  cov_sleep: cover property ($rose(sleep_block));
  cov_irq: cover property ($fell(irq));
endmodule

bind uopc_ctrl uopc_ctrl_sva i_sva (
  .core_clk, .rst_n, .hrdata, .hreadyout, .hresp, .error_flags,
  .sleep_req, .line_res, .bus_power_on, .bus_power_charge_en,
  .bus_power_discharge_en, .usb_clk_gate_en, .xcvr_low_power,
  .pins_owned, .sleep_block, .module_irq_out, .error_summary_irq, .irq);

// ==== verification/uopc_peer_model.sv ====
// Behavioural transceiver model that reports readiness to be enabled.
`timescale 1ns/1ps
module uopc_peer_model #(
  parameter int READY_CYC = 12
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Block side
  input  wire logic pins_owned,
  output logic      phy_ready
);
  logic [7:0] cnt_q;

  // The transceiver winds down for a while after release, so the busy
  // bit has a real window in which software must keep its hands off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'(READY_CYC);
    end else if (pins_owned) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'(READY_CYC)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign phy_ready = (cnt_q == 8'(READY_CYC));
endmodule

// ==== verification/uopc_ctrl_tb.sv ====
// Self-checking bench for the USB line, power and error control block.
`timescale 1ns/1ps
module uopc_ctrl_tb;
  localparam int         LAT = 6;
  localparam logic [7:0] LC  = uopc_pkg::OFS_LINE_CTRL;
  localparam logic [7:0] PC  = uopc_pkg::OFS_POWER_CTRL;
  localparam logic [7:0] EE  = uopc_pkg::OFS_ERR_EN;
  localparam logic [7:0] CLR = {4'h0, uopc_pkg::ALIAS_CLR};
  localparam logic [7:0] SET = {4'h0, uopc_pkg::ALIAS_SET};
  localparam logic [7:0] INV = {4'h0, uopc_pkg::ALIAS_INV};
  logic                 core_clk, rst_n, hsel, hwrite, hready, hresp;
  logic                 bus_activity, act_done, host_mode, sleep_req;
  logic                 phy_ready, bus_power_on, chg, dis, clk_gate;
  logic                 low_pw, pins_owned, sleep_block, module_irq_out;
  logic                 err_irq, irq;
  logic [1:0]           htrans;
  logic [3:0]           hw_line;
  logic [7:0]           error_flags;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  uopc_pkg::uopc_line_s line_res;
  int                   miscompares, n_checks;

  uopc_ctrl i_dut (
    .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
    .hw_line_dp_pu(hw_line[3]), .hw_line_dm_pu(hw_line[2]),
    .hw_line_dp_pd(hw_line[1]), .hw_line_dm_pd(hw_line[0]),
    .bus_activity, .activity_irq_done(act_done), .phy_ready,
    .error_flags, .host_mode, .sleep_req, .line_res, .bus_power_on,
    .bus_power_charge_en(chg), .bus_power_discharge_en(dis),
    .usb_clk_gate_en(clk_gate), .xcvr_low_power(low_pw), .pins_owned,
    .sleep_block, .module_irq_out, .error_summary_irq(err_irq), .irq);
  uopc_peer_model i_peer (.core_clk, .rst_n, .pins_owned, .phy_ready);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready and read data are taken at the rising edge, before the slave's
  // own update at that edge lands.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= uopc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic settle;
    repeat (LAT) @(posedge core_clk);
  endtask

  task automatic t_reset;
    rdc(LC, 32'h0);
    rdc(PC, 32'h0);
    rdc(EE, 32'h0);
    wr(8'h60, 32'hffff_ffff);
    rdc(8'h60, 32'h0);
    chk(low_pw, 1'b1);
  endtask

  task automatic t_line;
    hw_line <= 4'b1010;
    wr(LC, 32'hffff_ffff);
    rdc(LC, 32'hff);
    settle;
    chk({line_res, bus_power_on, pins_owned}, 32'h0);
    wr(PC, 32'h1);
    settle;
    chk({line_res, bus_power_on, chg, dis}, 32'h7f);
    wr(LC | CLR, 32'h7);
    settle;
    chk({line_res, chg, dis}, 32'h28);
    wr(LC | INV, 32'h88);
    wr(LC | SET, 32'h4);
    rdc(LC, 32'h74);
    settle;
    chk({line_res, bus_power_on}, 32'he);
    wr(PC | CLR, 32'h1);
    xfer(1'b0, PC, 32'h0, rd);
    chk(rd, 32'h8);
    for (int k = 0; k < 100 && rd[3] !== 1'b0; k++) begin
      xfer(1'b0, PC, 32'h0, rd);
    end
    chk(rd, 32'h0);
    chk({line_res, pins_owned}, 32'h0);
  endtask

  task automatic t_power;
    wr(PC, 32'hffff_ffff);
    rdc(PC, 32'h1b);
    settle;
    chk({clk_gate, low_pw}, 32'h1);
    wr(PC | CLR, 32'h2);
    settle;
    chk({clk_gate, low_pw}, 32'h2);
    bus_activity <= 1'b1;
    sleep_req    <= 1'b1;
    settle;
    chk(sleep_block, 1'b1);
    rdc(PC, 32'h99);
    bus_activity <= 1'b0;
    settle;
    chk(sleep_block, 1'b1);
    act_done <= 1'b1;
    settle;
    rdc(PC, 32'h19);
    chk(sleep_block, 1'b0);
    bus_activity <= 1'b1;
    wr(PC | CLR, 32'h10);
    settle;
    chk(sleep_block, 1'b0);
    bus_activity <= 1'b0;
    sleep_req    <= 1'b0;
  endtask

  task automatic t_err;
    wr(uopc_pkg::OFS_MAIN_IRQ, 32'h2);
    wr(uopc_pkg::OFS_EVT_MASK, 32'h2);
    for (int i = 0; i < 8; i++) begin
      host_mode <= i[0];
      wr(EE, 32'h1 << i);
      error_flags <= ~(8'h01 << i);
      settle;
      chk(err_irq, 1'b0);
      error_flags <= 8'h01 << i;
      settle;
      chk({err_irq, module_irq_out, irq}, 32'h7);
    end
    error_flags <= 8'h00;
    settle;
    chk(irq, 1'b1);
    xfer(1'b0, uopc_pkg::OFS_EVT_STATUS, 32'h0, rd);
    chk(rd & 32'h2, 32'h2);
    settle;
    chk(irq, 1'b0);
    wr(uopc_pkg::OFS_EVT_MASK, 32'h0);
    error_flags <= 8'h80;
    settle;
    chk({module_irq_out, irq}, 32'h2);
    wr(uopc_pkg::OFS_MAIN_IRQ | CLR, 32'h2);
    settle;
    chk({err_irq, module_irq_out}, 32'h2);
    error_flags <= 8'h00;
  endtask

  task automatic results;
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hw_line = 4'h0;
    bus_activity = 1'b0;
    act_done = 1'b0;
    host_mode = 1'b0;
    sleep_req = 1'b0;
    error_flags = 8'h00;
    miscompares = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_line;
    t_power;
    t_err;
    results;
  end

  // The sequence needs a few hundred cycles; this span leaves ample room.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    results;
  end
endmodule
